//--- osms_ext_load.sv
// Far-side load on the open-collector outputs: pull-ups and an external sink
`timescale 1ns/1ps

module osms_ext_load
    import osms_pkg::*;
(
    input  wire logic [OSMS_NUM_OC-1:0] oc_o,
    input  wire logic [OSMS_NUM_OC-1:0] oc_oe,
    input  wire logic [OSMS_NUM_OC-1:0] ext_sink,
    output logic      [OSMS_NUM_OC-1:0] pin_lvl
);
    // Pulled up unless either side sinks; o only counts while enabled
    assign pin_lvl = ~ext_sink & ~(oc_oe & ~oc_o);
endmodule // osms_ext_load

//--- osms_out_drive.sv
// Mode stage for the three outputs that share one index
`timescale 1ns/1ps

module osms_out_drive
    import osms_pkg::*;
(
    input  wire osms_out_mode_t mode,
    input  wire logic           dyn,
    output osms_out_lvl_t       lvl
);

    function automatic logic apply_mode(input logic [1:0] m, input logic d);
        case (m)
            OSMS_MODE_LOW:  apply_mode = 1'b0;
            OSMS_MODE_HIGH: apply_mode = 1'b1;
            OSMS_MODE_DYN:  apply_mode = d;
            default:        apply_mode = 1'b0;
        endcase
    endfunction

    // Same dynamic bit, separate mode per output
    assign lvl.diff = apply_mode(mode.diff, dyn);
    assign lvl.ttl  = apply_mode(mode.ttl, dyn);
    assign lvl.oc   = apply_mode(mode.oc, dyn);

endmodule // osms_out_drive

//--- osms_output_router.sv
// Output source and mode router with its AHB-Lite register slave
//
// Behaviour
// - The third select register holds the 8-bit source codes of indices 9, 10, 11 in bits 15..8, 23..16, 31..24, all read/write.
// - Differential, TTL and open-collector outputs of one index all take the one dynamic source of that index.
// - Each output can be forced high or low on its own, whatever its siblings do.
// - The TTL mode register holds a 2-bit field per index n at bits 2n+1..2n for n 0..11; bits 31..24 are reserved.
// - Mode 00 drives low, 01 drives high, 10 follows the dynamic source, 11 is reserved.
// - A TTL output in dynamic mode follows the select field of its own index.
// - Codes 0..15 pick camera-control channels 1..4 of grabbers 0..3 in order, 16..19 sequencer outputs 0..3.
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps

module osms_output_router
    import osms_pkg::*;
(
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      clk_en,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic                           hresp,
    output logic [31:0]                    hrdata,
    input  wire logic [OSMS_NUM_CC-1:0]    grabber_camctl,
    input  wire logic [OSMS_NUM_SEQ-1:0]   grabber0_seq_out,
    output logic [OSMS_NUM_IDX-1:0]        diff_out,
    output logic [OSMS_NUM_IDX-1:0]        ttl_out,
    output logic [OSMS_NUM_OC-1:0]         open_collector_out_o,
    output logic [OSMS_NUM_OC-1:0]         open_collector_out_oe,
    input  wire logic [OSMS_NUM_OC-1:0]    open_collector_out_i
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [3:0] byte_lanes(input logic [2:0] size,
                                              input logic [1:0] lo);
        logic [3:0] lanes;
        lanes = 4'hf;
        if (size == OSMS_HSIZE_BYTE) begin
            lanes = 4'h1 << lo;
        end else if (size == OSMS_HSIZE_HALF) begin
            lanes = lo[1] ? 4'hc : 4'h3;
        end
        return lanes;
    endfunction

    function automatic logic [31:0] merge_word(input logic [31:0] old_val,
                                               input logic [31:0] wdata,
                                               input logic [3:0]  lanes,
                                               input logic [31:0] mask);
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (lanes[b]) begin
                res[b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
        return res & mask;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    osms_bus_state_t             state_reg;
    osms_bus_state_t             state_next;
    osms_ahb_cmd_t               cmd_reg;
    osms_ahb_cmd_t               cmd_next;
    logic [31:0]                 hrdata_reg;
    logic [31:0]                 sel_a_reg;
    logic [31:0]                 sel_b_reg;
    logic [31:0]                 sel_c_reg;
    logic [31:0]                 mode_ttl_reg;
    logic [31:0]                 mode_diff_reg;
    logic [31:0]                 mode_oc_reg;
    logic [OSMS_NUM_IDX-1:0]     diff_out_reg;
    logic [OSMS_NUM_IDX-1:0]     ttl_out_reg;
    logic [OSMS_NUM_OC-1:0]      oc_lvl_reg;
    logic [OSMS_NUM_OC-1:0]      oc_meta_reg;
    logic [OSMS_NUM_OC-1:0]      oc_sense_reg;

    wire logic                   addr_phase;
    wire logic                   wr_active;
    wire logic                   wr_sel_a;
    wire logic                   wr_sel_b;
    wire logic                   wr_sel_c;
    wire logic                   wr_mode_ttl;
    wire logic                   wr_mode_diff;
    wire logic                   wr_mode_oc;
    wire logic [31:0]            sel_a_next;
    wire logic [31:0]            sel_b_next;
    wire logic [31:0]            sel_c_next;
    wire logic [31:0]            mode_ttl_next;
    wire logic [31:0]            mode_diff_next;
    wire logic [31:0]            mode_oc_next;
    wire logic [31:0]            status_word;
    wire logic [31:0]            rd_word;
    wire logic [31:0]            hrdata_next;
    wire logic [95:0]            sel_all;
    wire logic [OSMS_NUM_IDX-1:0] diff_out_next;
    wire logic [OSMS_NUM_IDX-1:0] ttl_out_next;
    wire logic [OSMS_NUM_IDX-1:0] oc_all_next;
    wire logic [OSMS_NUM_OC-1:0]  oc_lvl_next;

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite address phase and state

    assign addr_phase = hsel & hready & htrans[1];
    assign cmd_next   = addr_phase ? osms_ahb_cmd_t'{addr:  haddr[7:0],
                                                     lanes: byte_lanes(hsize, haddr[1:0]),
                                                     write: hwrite}
                                   : cmd_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            OSMS_BUS_IDLE, OSMS_BUS_WRITE, OSMS_BUS_RD_DONE: begin
                if (addr_phase) begin
                    state_next = hwrite ? OSMS_BUS_WRITE : OSMS_BUS_RD_WAIT;
                end else begin
                    state_next = OSMS_BUS_IDLE;
                end
            end
            OSMS_BUS_RD_WAIT: begin
                state_next = OSMS_BUS_RD_DONE;
            end
            default: begin
                state_next = OSMS_BUS_IDLE;
            end
        endcase
    end

    // One wait state on reads so read data always comes from a flop
    assign hreadyout = (state_reg != OSMS_BUS_RD_WAIT);
    assign hresp     = OSMS_HRESP_OKAY;
    assign hrdata    = hrdata_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= OSMS_BUS_IDLE;
            cmd_reg   <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
            cmd_reg   <= cmd_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes in the data phase

    assign wr_active    = (state_reg == OSMS_BUS_WRITE);
    assign wr_sel_a     = wr_active & (cmd_reg.addr == OSMS_SEL_A_ADDR);
    assign wr_sel_b     = wr_active & (cmd_reg.addr == OSMS_SEL_B_ADDR);
    assign wr_sel_c     = wr_active & (cmd_reg.addr == OSMS_SEL_C_ADDR);
    assign wr_mode_ttl  = wr_active & (cmd_reg.addr == OSMS_MODE_TTL_ADDR);
    assign wr_mode_diff = wr_active & (cmd_reg.addr == OSMS_MODE_DIFF_ADDR);
    assign wr_mode_oc   = wr_active & (cmd_reg.addr == OSMS_MODE_OC_ADDR);

    assign sel_a_next = wr_sel_a
        ? merge_word(sel_a_reg, hwdata, cmd_reg.lanes, OSMS_SEL_MASK) : sel_a_reg;
    assign sel_b_next = wr_sel_b
        ? merge_word(sel_b_reg, hwdata, cmd_reg.lanes, OSMS_SEL_MASK) : sel_b_reg;
    assign sel_c_next = wr_sel_c
        ? merge_word(sel_c_reg, hwdata, cmd_reg.lanes, OSMS_SEL_MASK) : sel_c_reg;
    // Reserved top byte is never stored, so it reads back zero
    assign mode_ttl_next = wr_mode_ttl
        ? merge_word(mode_ttl_reg, hwdata, cmd_reg.lanes, OSMS_MODE_MASK)
        : mode_ttl_reg;
    assign mode_diff_next = wr_mode_diff
        ? merge_word(mode_diff_reg, hwdata, cmd_reg.lanes, OSMS_MODE_MASK)
        : mode_diff_reg;
    assign mode_oc_next = wr_mode_oc
        ? merge_word(mode_oc_reg, hwdata, cmd_reg.lanes, OSMS_OC_MASK)
        : mode_oc_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_a_reg     <= OSMS_SEL_RESET;
            sel_b_reg     <= OSMS_SEL_RESET;
            sel_c_reg     <= OSMS_SEL_RESET;
            mode_ttl_reg  <= OSMS_MODE_RESET;
            mode_diff_reg <= OSMS_MODE_RESET;
            mode_oc_reg   <= OSMS_MODE_RESET;
        end else if (clk_en) begin
            sel_a_reg     <= sel_a_next;
            sel_b_reg     <= sel_b_next;
            sel_c_reg     <= sel_c_next;
            mode_ttl_reg  <= mode_ttl_next;
            mode_diff_reg <= mode_diff_next;
            mode_oc_reg   <= mode_oc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads

    assign status_word = {oc_sense_reg, oc_lvl_reg, diff_out_reg, ttl_out_reg};

    // Unmapped addresses read zero with an OKAY answer
    assign rd_word =
        (cmd_reg.addr == OSMS_SEL_A_ADDR)     ? sel_a_reg     :
        (cmd_reg.addr == OSMS_SEL_B_ADDR)     ? sel_b_reg     :
        (cmd_reg.addr == OSMS_SEL_C_ADDR)     ? sel_c_reg     :
        (cmd_reg.addr == OSMS_MODE_TTL_ADDR)  ? mode_ttl_reg  :
        (cmd_reg.addr == OSMS_MODE_DIFF_ADDR) ? mode_diff_reg :
        (cmd_reg.addr == OSMS_MODE_OC_ADDR)   ? mode_oc_reg   :
        (cmd_reg.addr == OSMS_STATUS_ADDR)    ? status_word   : 32'h0000_0000;

    assign hrdata_next = (state_reg == OSMS_BUS_RD_WAIT) ? rd_word : hrdata_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (clk_en) begin
            hrdata_reg <= hrdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-index source selection and output modes

    assign sel_all = {sel_c_reg, sel_b_reg, sel_a_reg};

    for (genvar i = 0; i < OSMS_NUM_IDX; i++) begin : g_idx
        wire logic           dyn;
        wire osms_out_mode_t mode;
        wire osms_out_lvl_t  lvl;

        // Field i of the flat select space; index 9 sits at bits 15..8 of C
        osms_src_mux u_src (
            .sel              (sel_all[i*OSMS_SEL_STRIDE +: OSMS_SEL_W]),
            .grabber_camctl   (grabber_camctl),
            .grabber0_seq_out (grabber0_seq_out),
            .dyn              (dyn)
        );

        assign mode.ttl  = mode_ttl_reg[i*OSMS_MODE_STRIDE +: OSMS_MODE_W];
        assign mode.diff = mode_diff_reg[i*OSMS_MODE_STRIDE +: OSMS_MODE_W];
        if (i >= OSMS_OC_BASE_IDX) begin : g_oc
            assign mode.oc = mode_oc_reg[(i-OSMS_OC_BASE_IDX)*OSMS_MODE_STRIDE
                                         +: OSMS_MODE_W];
        end else begin : g_no_oc
            assign mode.oc = OSMS_MODE_LOW;
        end

        osms_out_drive u_drive (
            .mode (mode),
            .dyn  (dyn),
            .lvl  (lvl)
        );

        assign diff_out_next[i] = lvl.diff;
        assign ttl_out_next[i]  = lvl.ttl;
        assign oc_all_next[i]   = lvl.oc;
    end

    assign oc_lvl_next = oc_all_next[OSMS_NUM_IDX-1:OSMS_OC_BASE_IDX];

    ////////////////////////////////////////////////////////////////////////////
    // Output flops and open-collector pin sensing

    // Registered outputs trade one cycle of latency for glitch-free pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            diff_out_reg <= '0;
            ttl_out_reg  <= '0;
            oc_lvl_reg   <= '0;
        end else if (clk_en) begin
            diff_out_reg <= diff_out_next;
            ttl_out_reg  <= ttl_out_next;
            oc_lvl_reg   <= oc_lvl_next;
        end
    end

    // Pin readback crosses in from outside, two flops before use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oc_meta_reg  <= '0;
            oc_sense_reg <= '0;
        end else if (clk_en) begin
            oc_meta_reg  <= open_collector_out_i;
            oc_sense_reg <= oc_meta_reg;
        end
    end

    assign diff_out = diff_out_reg;
    assign ttl_out  = ttl_out_reg;

    // Open collector only sinks: a low level turns the transistor on
    assign open_collector_out_o  = '0;
    assign open_collector_out_oe = ~oc_lvl_reg;

endmodule // osms_output_router

//--- osms_output_router_checker.sv
// Assertions on bus timing and output levels of the output router
`timescale 1ns/1ps

module osms_output_router_checker
    import osms_pkg::*;
(
    input wire logic                    hclk,
    input wire logic                    hresetn,
    input wire logic                    clk_en,
    input wire logic                    hsel,
    input wire logic [31:0]             haddr,
    input wire logic [1:0]              htrans,
    input wire logic                    hwrite,
    input wire logic [31:0]             hwdata,
    input wire logic                    hready,
    input wire logic                    hreadyout,
    input wire logic [OSMS_NUM_CC-1:0]  grabber_camctl,
    input wire logic [OSMS_NUM_SEQ-1:0] grabber0_seq_out,
    input wire logic [OSMS_NUM_IDX-1:0] diff_out,
    input wire logic [OSMS_NUM_IDX-1:0] ttl_out
);
    // Shadows assume word writes only
    logic        taken, wr_q;
    logic [7:0]  addr_q;
    logic [31:0] selc_reg, ttl_reg, diff_reg;
    logic [11:0] t_lo, t_hi, d_lo, d_hi;
    logic [2:0]  t_dyn, d_dyn, both_dyn, src_exp, bad_sel, dyn_bad;

    function automatic logic pick(logic [7:0] s, logic [15:0] cc, logic [3:0] sq);
        if (s < 8'h10) return cc[s[3:0]];
        if (s < 8'h14) return sq[s[1:0]];
        return 1'b0;
    endfunction

    assign taken = clk_en && hsel && hready && htrans[1];
    assign both_dyn = t_dyn & d_dyn;
    assign dyn_bad = t_dyn & bad_sel;
    for (genvar i = 0; i < 12; i++) begin : g_mode
        assign t_lo[i] = ttl_reg[2*i+:2] == OSMS_MODE_LOW || ttl_reg[2*i+:2] == 2'h3;
        assign t_hi[i] = ttl_reg[2*i+:2] == OSMS_MODE_HIGH;
        assign d_lo[i] = diff_reg[2*i+:2] == OSMS_MODE_LOW || diff_reg[2*i+:2] == 2'h3;
        assign d_hi[i] = diff_reg[2*i+:2] == OSMS_MODE_HIGH;
    end
    for (genvar k = 0; k < 3; k++) begin : g_dyn
        assign src_exp[k] = pick(selc_reg[8*k+8+:8], grabber_camctl, grabber0_seq_out);
        assign bad_sel[k] = selc_reg[8*k+8+:8] >= OSMS_SRC_CODE_LIMIT;
        assign t_dyn[k] = ttl_reg[2*k+18+:2] == OSMS_MODE_DYN;
        assign d_dyn[k] = diff_reg[2*k+18+:2] == OSMS_MODE_DYN;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            addr_q <= 8'h00;
            selc_reg <= 32'h0;
            ttl_reg <= 32'h0;
            diff_reg <= 32'h0;
        end else if (clk_en && hready) begin
            wr_q <= taken && hwrite;
            addr_q <= haddr[7:0];
            if (wr_q && addr_q == OSMS_SEL_C_ADDR) selc_reg <= hwdata;
            if (wr_q && addr_q == OSMS_MODE_TTL_ADDR) ttl_reg <= hwdata;
            if (wr_q && addr_q == OSMS_MODE_DIFF_ADDR) diff_reg <= hwdata;
        end
    end

    ////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_ttl_low;
        (ttl_out & $past(t_lo)) == 12'h0;
    endproperty
    a_ttl_low: assert property (p_ttl_low)
        else $error("ttl output high in a low mode");
    property p_ttl_high;
        (ttl_out & $past(t_hi)) == $past(t_hi);
    endproperty
    a_ttl_high: assert property (p_ttl_high)
        else $error("ttl output low in the high mode");
    property p_diff_static;
        ((diff_out & $past(d_lo)) == 12'h0) && ((diff_out & $past(d_hi)) == $past(d_hi));
    endproperty
    a_diff_static: assert property (p_diff_static)
        else $error("diff output not at its forced level");
    property p_ttl_dyn;
        (ttl_out[11:9] & $past(t_dyn)) == ($past(src_exp) & $past(t_dyn));
    endproperty
    a_ttl_dyn: assert property (p_ttl_dyn)
        else $error("ttl output does not follow its source");
    property p_shared_src;
        (diff_out[11:9] & $past(both_dyn)) == (ttl_out[11:9] & $past(both_dyn));
    endproperty
    a_shared_src: assert property (p_shared_src)
        else $error("diff and ttl of one index differ in dynamic mode");
    property p_rsvd_sel;
        (ttl_out[11:9] & $past(dyn_bad)) == 3'h0;
    endproperty
    a_rsvd_sel: assert property (p_rsvd_sel)
        else $error("reserved source code drives high");
    property p_write_ready;
        taken && hwrite |=> hreadyout;
    endproperty
    a_write_ready: assert property (p_write_ready)
        else $error("write data phase stalled");
    property p_read_wait;
        taken && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read answer not after one wait state");
endmodule // osms_output_router_checker

bind osms_output_router osms_output_router_checker chk_u (.hclk, .hresetn, .clk_en, .hsel,
    .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .grabber_camctl,
    .grabber0_seq_out, .diff_out, .ttl_out);

//--- osms_output_router_tb.sv
// Self-checking testbench of the output router
`timescale 1ns/1ps

module osms_output_router_tb
    import osms_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        clk_en = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout, hresp;
    logic [31:0] hrdata, rd;
    logic [15:0] cc = 16'h0;
    logic [3:0]  seq = 4'h0, sink = 4'h0;
    logic        run_src = 1'b1;
    logic [11:0] diff_out, ttl_out;
    logic [3:0]  oc_o, oc_oe, oc_pin;
    logic [31:0] selc, tm, dm, om;
    logic [7:0]  corner [6] = '{8'h00, 8'h0f, 8'h10, 8'h13, 8'h14, 8'hff};
    int          failures = 0;
    int          samples_checked = 0;

    always #25 hclk = ~hclk;
    always @(posedge hclk) begin
        if (run_src) begin
            cc <= 16'($urandom);
            seq <= 4'($urandom);
            sink <= 4'($urandom);
        end
    end

    osms_output_router dut_u (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .grabber_camctl(cc),
        .grabber0_seq_out(seq), .diff_out, .ttl_out, .open_collector_out_o(oc_o),
        .open_collector_out_oe(oc_oe), .open_collector_out_i(oc_pin));
    osms_ext_load load_u (.oc_o, .oc_oe, .ext_sink(sink), .pin_lvl(oc_pin));

    ////////////////////////////////////////
    function automatic logic lvl(logic [1:0] m, logic [7:0] s);
        logic src;
        src = s < 8'h10 ? cc[s[3:0]] : (s < 8'h14 ? seq[s[1:0]] : 1'b0);
        return m == 2'h1 ? 1'b1 : (m == 2'h2 ? src : 1'b0);
    endfunction
    // Select A and B stay at reset, so indices 0..7 use code 0
    function automatic logic [31:0] exp_out(logic [31:0] m);
        exp_out = 32'h0;
        for (int i = 0; i < 12; i++) exp_out[i] = lvl(m[2*i+:2], i < 8 ? 8'h0 : selc[8*i-64+:8]);
    endfunction
    function automatic logic [31:0] exp_oe();
        exp_oe = 32'h0;
        for (int k = 0; k < 4; k++) exp_oe[k] = ~lvl(om[2*k+:2], selc[8*k+:8]);
    endfunction
    // Status: synced pin sense, oc levels, diff, ttl; pin is low if either side sinks
    function automatic logic [31:0] exp_stat();
        logic [31:0] oe, d, t;
        oe = exp_oe();
        d = exp_out(dm);
        t = exp_out(tm);
        return {~sink & ~oe[3:0], ~oe[3:0], d[11:0], t[11:0]};
    endfunction

    task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Ready is combinational from state, so it is judged mid-cycle
    task automatic wait_rdy;
        int n = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) failures++;
            if (n > 20) summarize();
            @(negedge hclk);
        end
    endtask
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_rdy();
        @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        @(posedge hclk);
        rd = hrdata;
        chk(32'(hresp), 32'(OSMS_HRESP_OKAY), "resp");
    endtask
    task automatic check_outs;
        run_src <= 1'b0;
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        chk(32'(ttl_out), exp_out(tm), "ttl");
        chk(32'(diff_out), exp_out(dm), "diff");
        chk(32'(oc_oe), exp_oe(), "oc");
        chk(32'(oc_o), 32'h0, "oc sink only");
        @(posedge hclk);
        bus(1'b0, OSMS_STATUS_ADDR, 32'h0);
        chk(rd, exp_stat(), "status");
        run_src <= 1'b1;
    endtask

    ////////////////////////////////////////
    initial begin
        #250000;
        failures++;
        summarize();
    end
    initial begin
        void'($urandom(32'hd8d113ad));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, OSMS_SEL_C_ADDR, 32'h0);
        chk(rd, 32'h0, "sel reset");
        bus(1'b0, OSMS_MODE_TTL_ADDR, 32'h0);
        chk(rd, 32'h0, "mode reset");
        bus(1'b1, OSMS_SEL_C_ADDR, 32'ha5c3_0f96);
        bus(1'b1, OSMS_MODE_TTL_ADDR, 32'hffff_ffff);
        bus(1'b1, 8'h1c, 32'hffff_ffff);
        bus(1'b0, OSMS_SEL_C_ADDR, 32'h0);
        chk(rd, 32'ha5c3_0f96, "sel rw");
        bus(1'b0, OSMS_MODE_TTL_ADDR, 32'h0);
        chk(rd, 32'h00ff_ffff, "mode rw");
        bus(1'b0, 8'h1c, 32'h0);
        chk(rd, 32'h0, "unmapped");
        // Corner codes and every mode first, then random mixes
        for (int it = 0; it < 40; it++) begin
            for (int k = 0; k < 4; k++) selc[8*k+:8] = it < 6 ? corner[it] : 8'($urandom_range(0, 23));
            tm = it < 8 ? 32'({12{2'(it)}}) : $urandom;
            dm = it < 8 ? 32'({12{2'(it + 1)}}) : $urandom;
            om = $urandom;
            bus(1'b1, OSMS_SEL_C_ADDR, selc);
            bus(1'b1, OSMS_MODE_TTL_ADDR, tm);
            bus(1'b1, OSMS_MODE_DIFF_ADDR, dm);
            bus(1'b1, OSMS_MODE_OC_ADDR, om);
            check_outs();
        end
        // Reset in mid-run must bring every register and pin back to static low
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        selc = 32'h0;
        tm = 32'h0;
        dm = 32'h0;
        om = 32'h0;
        check_outs();
        summarize();
    end
endmodule // osms_output_router_tb

//--- osms_pkg.sv
// Package: constants and types of the output source and mode router
package osms_pkg;

    // Structure of the output matrix
    localparam int OSMS_NUM_IDX     = 12;
    localparam int OSMS_NUM_OC      = 4;
    localparam int OSMS_OC_BASE_IDX = 8;
    localparam int OSMS_SEL_W       = 8;
    localparam int OSMS_MODE_W      = 2;
    localparam int OSMS_NUM_CC      = 16;
    localparam int OSMS_NUM_SEQ     = 4;
    localparam int OSMS_NUM_SRC     = 20;
    localparam int OSMS_SRC_IDX_W   = 5;

    // First code past the last defined source; it and all above are reserved
    localparam logic [7:0] OSMS_SRC_CODE_LIMIT = 8'h14;

    // Field layout: select fields 8 bits apart, mode fields 2 bits apart
    localparam int OSMS_SEL_STRIDE  = 8;
    localparam int OSMS_MODE_STRIDE = 2;
    localparam int OSMS_SEL_IDX9_LSB  = 8;
    localparam int OSMS_SEL_IDX10_LSB = 16;
    localparam int OSMS_SEL_IDX11_LSB = 24;

    // Mode field codes; 2'h3 is reserved
    localparam logic [1:0] OSMS_MODE_LOW  = 2'h0;
    localparam logic [1:0] OSMS_MODE_HIGH = 2'h1;
    localparam logic [1:0] OSMS_MODE_DYN  = 2'h2;

    // Register byte addresses
    localparam logic [7:0] OSMS_SEL_A_ADDR     = 8'h00;
    localparam logic [7:0] OSMS_SEL_B_ADDR     = 8'h04;
    localparam logic [7:0] OSMS_SEL_C_ADDR     = 8'h08;
    localparam logic [7:0] OSMS_MODE_TTL_ADDR  = 8'h0c;
    localparam logic [7:0] OSMS_MODE_DIFF_ADDR = 8'h10;
    localparam logic [7:0] OSMS_MODE_OC_ADDR   = 8'h14;
    localparam logic [7:0] OSMS_STATUS_ADDR    = 8'h18;

    // Writable bits of each register; the rest read as zero
    localparam logic [31:0] OSMS_SEL_MASK  = 32'hffff_ffff;
    localparam logic [31:0] OSMS_MODE_MASK = 32'h00ff_ffff;
    localparam logic [31:0] OSMS_OC_MASK   = 32'h0000_00ff;

    // Values after reset: every output static low
    localparam logic [31:0] OSMS_SEL_RESET  = 32'h0000_0000;
    localparam logic [31:0] OSMS_MODE_RESET = 32'h0000_0000;

    // Status register layout
    localparam int OSMS_STAT_TTL_LSB   = 0;
    localparam int OSMS_STAT_DIFF_LSB  = 12;
    localparam int OSMS_STAT_OC_LSB    = 24;
    localparam int OSMS_STAT_SENSE_LSB = 28;

    // AHB-Lite encodings
    localparam logic [2:0] OSMS_HSIZE_BYTE = 3'h0;
    localparam logic [2:0] OSMS_HSIZE_HALF = 3'h1;
    localparam logic       OSMS_HRESP_OKAY = 1'b0;

    typedef enum logic [3:0] {
        OSMS_BUS_IDLE    = 4'b0001,
        OSMS_BUS_WRITE   = 4'b0010,
        OSMS_BUS_RD_WAIT = 4'b0100,
        OSMS_BUS_RD_DONE = 4'b1000
    } osms_bus_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [3:0] lanes;
        logic       write;
    } osms_ahb_cmd_t;

    typedef struct packed {
        logic [1:0] diff;
        logic [1:0] ttl;
        logic [1:0] oc;
    } osms_out_mode_t;

    typedef struct packed {
        logic diff;
        logic ttl;
        logic oc;
    } osms_out_lvl_t;

endpackage

//--- osms_src_mux.sv
// Dynamic source selector for one output index
`timescale 1ns/1ps

module osms_src_mux
    import osms_pkg::*;
(
    input  wire logic [OSMS_SEL_W-1:0]   sel,
    input  wire logic [OSMS_NUM_CC-1:0]  grabber_camctl,
    input  wire logic [OSMS_NUM_SEQ-1:0] grabber0_seq_out,
    output logic                         dyn
);

    wire logic [OSMS_NUM_SRC-1:0]   src_vec;
    wire logic                      sel_valid;
    wire logic [OSMS_SRC_IDX_W-1:0] sel_idx;

    // Codes 0..15 camera control in grabber order, 16..19 sequencer
    assign src_vec   = {grabber0_seq_out, grabber_camctl};
    assign sel_valid = sel < OSMS_SRC_CODE_LIMIT;
    assign sel_idx   = sel[OSMS_SRC_IDX_W-1:0];
    // Reserved codes give a quiet low rather than an undefined pick
    assign dyn       = sel_valid ? src_vec[sel_idx] : 1'b0;

endmodule // osms_src_mux
